// >>> common/eeprom_pkg.sv
/*
  Shared constants and types for the serial EEPROM command port.
  Assumes a 250 MHz system clock and a host clock sampled as a plain input.
*/
package eeprom_pkg;
  // ----------------------------------------------------------------
  // Array shape
  // ----------------------------------------------------------------
  localparam int WORD_W = 16;
  localparam int BYTE_W = 8;
  localparam int WORDS = 64;
  localparam int ADDR_W = 7;
  localparam int FIFO_DEPTH = 32;
  localparam int HDR_BITS_WORD = 8;
  localparam int HDR_BITS_BYTE = 9;
  localparam logic [WORD_W-1:0] MEM_RESET = 16'hffff;
  localparam logic [WORD_W-1:0] ERASED = 16'hffff;
  // ----------------------------------------------------------------
  // Opcodes
  // ----------------------------------------------------------------
  localparam logic [1:0] OP_EXT = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_ERASE = 2'h3;
  localparam logic [1:0] EXT_WDS = 2'h0;
  localparam logic [1:0] EXT_WRITE_ALL_CMD = 2'h1;
  localparam logic [1:0] EXT_ERASE_ALL_CMD = 2'h2;
  localparam logic [1:0] EXT_WEN = 2'h3;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam longint CLK_PERIOD_PS = 4000;
  localparam longint PROG_ONE_MS = 3;
  localparam longint PROG_ALL_MS = 5;
  localparam longint PROG_ONE_CYC = (PROG_ONE_MS * 64'd1000000000) / CLK_PERIOD_PS;
  localparam longint PROG_ALL_CYC = (PROG_ALL_MS * 64'd1000000000) / CLK_PERIOD_PS;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    S_IDLE = 5'h01,
    S_HDR = 5'h02,
    S_DATA = 5'h04,
    S_READ = 5'h08,
    S_WAIT = 5'h10
  } port_state_e;
  typedef struct packed {
    logic organization_select;
    logic din;
    logic sk;
    logic cs;
  } pin_in_s;
  localparam pin_in_s PIN_RESET = 4'h8;
  typedef struct packed {
    logic [1:0] op;
    logic [1:0] ext;
    logic [ADDR_W-1:0] addr;
  } cmd_s;
endpackage : eeprom_pkg

// >>> design/serial_eeprom_command_port.sv
/*
  Serial command port of a 1-Kbit nonvolatile array with a read prefetch FIFO.
  Assumes host pins are asynchronous and the host clock is far below 1/6 of i_clk_sys.
*/
// Function
// - Start bit, opcode, address, optional data
// - Nine-bit or ten-bit instruction header lengths
// - Sample input on serial clock rising edge
// - Output high impedance except read or status
// - Status low while busy, high when ready
// - Shifted one bit releases status output
// - Status release refused while busy
// - Read: dummy zero, then word MSB first
// - Read bits change on rising clock edge
// - Sequential read increments and wraps to zero
// - Dummy zero only before first word
// - Powers up write disabled; enable first
// - Enable latch holds until disable or power loss
// - Reads work whatever the latch state
// - Program cycle within 3 ms or 5 ms
// - Program cycle starts on select falling edge
// - Erase leaves affected bits at one
// - Organization high selects word mode
`timescale 1ns/1ns
module read_fifo #(
  parameter int W = 16,
  parameter int DEPTH = 32
) (
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic i_flush,
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [W-1:0] i_data,
  output logic o_valid,
  input wire logic i_ready,
  output logic [W-1:0] o_data
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem_q [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;
  assign o_ready = cnt_q != (AW+1)'(DEPTH);
  assign o_valid = cnt_q != '0;
  assign o_data = mem_q[rp_q];
  assign push = i_valid & o_ready;
  assign pop = o_valid & i_ready;
  // Pointers wrap naturally, so DEPTH must be a power of two
  always_ff @(posedge i_clk_sys or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end
    else if (i_flush)
    begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end
    else
    begin
      wp_q <= wp_q + AW'(push);
      rp_q <= rp_q + AW'(pop);
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
  always_ff @(posedge i_clk_sys)
  begin
    if (push)
      mem_q[wp_q] <= i_data;
  end
endmodule : read_fifo

module serial_eeprom_command_port #(
  parameter int unsigned PROG_ONE_CYC = 32'(eeprom_pkg::PROG_ONE_CYC),
  parameter int unsigned PROG_ALL_CYC = 32'(eeprom_pkg::PROG_ALL_CYC),
  parameter int FIFO_DEPTH = eeprom_pkg::FIFO_DEPTH
) (
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic i_cs,
  input wire logic i_serial_clock_in,
  input wire logic i_serial_in,
  input wire logic i_organization_select,
  output logic o_serial_out,
  output logic o_serial_out_oe,
  output logic o_busy,
  output logic o_write_enabled
);
  localparam int TW = $clog2(PROG_ALL_CYC + 1);
  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  eeprom_pkg::pin_in_s s1_q;
  eeprom_pkg::pin_in_s s2_q;
  eeprom_pkg::pin_in_s s3_q;
  eeprom_pkg::pin_in_s f_q;
  logic sk_prev_q;
  logic cs_prev_q;
  logic sk_rise;
  logic cs_rise;
  logic cs_fall;
  always_ff @(posedge i_clk_sys or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      s1_q <= eeprom_pkg::PIN_RESET;
      s2_q <= eeprom_pkg::PIN_RESET;
      s3_q <= eeprom_pkg::PIN_RESET;
      f_q <= eeprom_pkg::PIN_RESET;
      sk_prev_q <= 1'b0;
      cs_prev_q <= 1'b0;
    end
    else
    begin
      s1_q <= {i_organization_select, i_serial_in, i_serial_clock_in, i_cs};
      s2_q <= s1_q;
      s3_q <= s2_q;
      // A bit changes only once the second and third stages agree
      f_q <= (s2_q & s3_q) | (f_q & (s2_q | s3_q));
      sk_prev_q <= f_q.sk;
      cs_prev_q <= f_q.cs;
    end
  end
  assign sk_rise = f_q.sk & ~sk_prev_q;
  assign cs_rise = f_q.cs & ~cs_prev_q;
  assign cs_fall = ~f_q.cs & cs_prev_q;
  // ----------------------------------------------------------------
  // Instruction decode
  // ----------------------------------------------------------------
  eeprom_pkg::port_state_e st_q;
  eeprom_pkg::cmd_s cmd_q;
  logic [4:0] cnt_q;
  logic [8:0] hdr_q;
  logic [8:0] nh;
  logic [15:0] dat_q;
  logic word_mode_q;
  logic wen_q;
  logic busy_q;
  logic show_q;
  logic stat_pend_q;
  logic [1:0] dec_op;
  logic [1:0] dec_ext;
  logic [6:0] dec_addr;
  logic needs_data;
  logic hdr_done;
  logic data_done;
  logic start_ok;
  logic is_prog;
  logic prog_start;
  assign nh = {hdr_q[7:0], f_q.din};
  assign dec_op = word_mode_q ? nh[7:6] : nh[8:7];
  assign dec_addr = word_mode_q ? {1'b0, nh[5:0]} : nh[6:0];
  assign dec_ext = word_mode_q ? nh[5:4] : nh[6:5];
  assign needs_data = dec_op == eeprom_pkg::OP_WRITE ||
                      (dec_op == eeprom_pkg::OP_EXT && dec_ext == eeprom_pkg::EXT_WRITE_ALL_CMD);
  assign hdr_done = st_q == eeprom_pkg::S_HDR && sk_rise &&
                    cnt_q == (word_mode_q ? 5'(eeprom_pkg::HDR_BITS_WORD - 1) :
                                            5'(eeprom_pkg::HDR_BITS_BYTE - 1));
  assign data_done = st_q == eeprom_pkg::S_DATA && sk_rise &&
                     cnt_q == (word_mode_q ? 5'(eeprom_pkg::WORD_W - 1) : 5'(eeprom_pkg::BYTE_W - 1));
  // Start bits are ignored while a program cycle runs
  assign start_ok = st_q == eeprom_pkg::S_IDLE && f_q.cs && sk_rise && f_q.din && !busy_q;
  assign is_prog = cmd_q.op == eeprom_pkg::OP_WRITE || cmd_q.op == eeprom_pkg::OP_ERASE ||
                   (cmd_q.op == eeprom_pkg::OP_EXT &&
                    (cmd_q.ext == eeprom_pkg::EXT_ERASE_ALL_CMD || cmd_q.ext == eeprom_pkg::EXT_WRITE_ALL_CMD));
  assign prog_start = cs_fall && st_q == eeprom_pkg::S_WAIT && is_prog && wen_q;
  always_ff @(posedge i_clk_sys or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      st_q <= eeprom_pkg::S_IDLE;
      cnt_q <= '0;
      hdr_q <= '0;
      dat_q <= '0;
      cmd_q <= '0;
      word_mode_q <= 1'b1;
    end
    else if (!f_q.cs)
      st_q <= eeprom_pkg::S_IDLE;
    else
    begin
      unique case (st_q)
        eeprom_pkg::S_IDLE:
        begin
          if (start_ok)
          begin
            st_q <= eeprom_pkg::S_HDR;
            cnt_q <= '0;
            word_mode_q <= f_q.organization_select;
          end
        end
        eeprom_pkg::S_HDR:
        begin
          if (sk_rise)
          begin
            hdr_q <= nh;
            cnt_q <= 5'(cnt_q + 5'h01);
            if (hdr_done)
            begin
              cmd_q <= {dec_op, dec_ext, dec_addr};
              cnt_q <= '0;
              if (dec_op == eeprom_pkg::OP_READ)
                st_q <= eeprom_pkg::S_READ;
              else if (needs_data)
                st_q <= eeprom_pkg::S_DATA;
              else
                st_q <= eeprom_pkg::S_WAIT;
            end
          end
        end
        eeprom_pkg::S_DATA:
        begin
          if (sk_rise)
          begin
            dat_q <= {dat_q[14:0], f_q.din};
            cnt_q <= 5'(cnt_q + 5'h01);
            if (data_done)
              st_q <= eeprom_pkg::S_WAIT;
          end
        end
        eeprom_pkg::S_READ, eeprom_pkg::S_WAIT:
          st_q <= st_q;
        default:
          st_q <= eeprom_pkg::S_IDLE;
      endcase
    end
  end
  // Write-enable latch, cleared only by power-on reset or disable
  always_ff @(posedge i_clk_sys or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      wen_q <= 1'b0;
    else if (hdr_done && dec_op == eeprom_pkg::OP_EXT && dec_ext == eeprom_pkg::EXT_WEN)
      wen_q <= 1'b1;
    else if (hdr_done && dec_op == eeprom_pkg::OP_EXT && dec_ext == eeprom_pkg::EXT_WDS)
      wen_q <= 1'b0;
  end
  // ----------------------------------------------------------------
  // Self-timed program cycle
  // ----------------------------------------------------------------
  logic [TW-1:0] tmr_q;
  logic prog_all;
  assign prog_all = cmd_q.op == eeprom_pkg::OP_EXT;
  always_ff @(posedge i_clk_sys or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      busy_q <= 1'b0;
      tmr_q <= '0;
    end
    else if (prog_start)
    begin
      busy_q <= 1'b1;
      tmr_q <= prog_all ? TW'(PROG_ALL_CYC - 1) : TW'(PROG_ONE_CYC - 1);
    end
    else if (busy_q)
    begin
      if (tmr_q == '0)
        busy_q <= 1'b0;
      else
        tmr_q <= tmr_q - TW'(1);
    end
  end
  // ----------------------------------------------------------------
  // Array storage
  // ----------------------------------------------------------------
  logic [15:0] mem_q [eeprom_pkg::WORDS];
  logic [15:0] wr_word;
  logic [15:0] wr_mask;
  logic hit_all;
  assign hit_all = cmd_q.op == eeprom_pkg::OP_EXT;
  assign wr_word = (cmd_q.op == eeprom_pkg::OP_ERASE || cmd_q.ext == eeprom_pkg::EXT_ERASE_ALL_CMD && hit_all) ?
                   eeprom_pkg::ERASED : (word_mode_q ? dat_q : {dat_q[7:0], dat_q[7:0]});
  assign wr_mask = (word_mode_q || hit_all) ? 16'hffff : (cmd_q.addr[0] ? 16'hff00 : 16'h00ff);
  for (genvar gi = 0; gi < eeprom_pkg::WORDS; gi++)
  begin : g_word
    logic hit;
    assign hit = hit_all || (word_mode_q ? cmd_q.addr[5:0] == 6'(gi) : cmd_q.addr[6:1] == 6'(gi));
    always_ff @(posedge i_clk_sys or posedge i_sys_rst)
    begin
      if (i_sys_rst)
        mem_q[gi] <= eeprom_pkg::MEM_RESET;
      else if (prog_start && hit)
        mem_q[gi] <= (mem_q[gi] & ~wr_mask) | (wr_word & wr_mask);
    end
  end
  // ----------------------------------------------------------------
  // Read prefetch and shifter
  // ----------------------------------------------------------------
  logic [6:0] pf_addr_q;
  logic pf_run_q;
  logic [15:0] pf_word;
  logic [15:0] pf_data;
  logic fifo_ready;
  logic fifo_valid;
  logic [15:0] fifo_head;
  logic fifo_push;
  logic fifo_pop;
  logic fifo_flush;
  logic rd_start;
  logic [15:0] sh_q;
  logic [4:0] bits_q;
  assign rd_start = hdr_done && dec_op == eeprom_pkg::OP_READ;
  assign fifo_flush = rd_start || !f_q.cs;
  assign pf_word = mem_q[word_mode_q ? pf_addr_q[5:0] : pf_addr_q[6:1]];
  assign pf_data = word_mode_q ? pf_word : {8'h00, pf_addr_q[0] ? pf_word[15:8] : pf_word[7:0]};
  assign fifo_push = pf_run_q && fifo_ready;
  assign fifo_pop = st_q == eeprom_pkg::S_READ && f_q.cs && sk_rise && bits_q == '0 && fifo_valid;
  always_ff @(posedge i_clk_sys or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      pf_addr_q <= '0;
      pf_run_q <= 1'b0;
    end
    else if (!f_q.cs)
      pf_run_q <= 1'b0;
    else if (rd_start)
    begin
      pf_addr_q <= dec_addr;
      pf_run_q <= 1'b1;
    end
    else if (fifo_push)
      pf_addr_q <= word_mode_q ? {1'b0, 6'(pf_addr_q[5:0] + 6'h01)} : 7'(pf_addr_q + 7'h01);
  end
  read_fifo #(
    .W(eeprom_pkg::WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_clk_sys(i_clk_sys),
    .i_sys_rst(i_sys_rst),
    .i_flush(fifo_flush),
    .i_valid(pf_run_q),
    .o_ready(fifo_ready),
    .i_data(pf_data),
    .o_valid(fifo_valid),
    .i_ready(fifo_pop),
    .o_data(fifo_head)
  );
  always_ff @(posedge i_clk_sys or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      sh_q <= '0;
      bits_q <= '0;
    end
    else if (rd_start)
    begin
      sh_q <= '0;
      bits_q <= '0;
    end
    else if (st_q == eeprom_pkg::S_READ && f_q.cs && sk_rise)
    begin
      if (bits_q == '0)
      begin
        // Next word follows with no dummy bit
        sh_q <= !fifo_valid ? 16'hffff : (word_mode_q ? fifo_head : {fifo_head[7:0], 8'h00});
        bits_q <= word_mode_q ? 5'(eeprom_pkg::WORD_W - 1) : 5'(eeprom_pkg::BYTE_W - 1);
      end
      else
      begin
        sh_q <= {sh_q[14:0], 1'b0};
        bits_q <= 5'(bits_q - 5'h01);
      end
    end
  end
  // ----------------------------------------------------------------
  // Status and output pin
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      show_q <= 1'b0;
      stat_pend_q <= 1'b0;
    end
    else
    begin
      if (!f_q.cs)
        show_q <= 1'b0;
      else if (cs_rise && stat_pend_q)
        show_q <= 1'b1;
      else if (start_ok && show_q)
        show_q <= 1'b0;
      if (prog_start)
        stat_pend_q <= 1'b1;
      else if (start_ok && show_q)
        stat_pend_q <= 1'b0;
    end
  end
  always_ff @(posedge i_clk_sys or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      o_serial_out <= 1'b0;
      o_serial_out_oe <= 1'b0;
      o_busy <= 1'b0;
      o_write_enabled <= 1'b0;
    end
    else
    begin
      o_serial_out_oe <= f_q.cs && (st_q == eeprom_pkg::S_READ || show_q);
      o_serial_out <= st_q == eeprom_pkg::S_READ ? sh_q[15] : ~busy_q;
      o_busy <= busy_q;
      o_write_enabled <= wen_q;
    end
  end
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);
  a_oe_only_valid: assert property (o_serial_out_oe |-> $past(st_q == eeprom_pkg::S_READ || show_q))
    else $error("output driven outside read or status");
  a_status_value: assert property ((o_serial_out_oe && $past(st_q) != eeprom_pkg::S_READ)
    |-> o_serial_out == !$past(busy_q))
    else $error("status level wrong");
  a_status_release: assert property ((show_q && start_ok) |=> !show_q ##1 !o_serial_out_oe)
    else $error("status not released");
  a_busy_keeps_status: assert property ((show_q && busy_q && f_q.cs) |=> show_q)
    else $error("status released while busy");
  a_dummy_first: assert property ($rose(st_q == eeprom_pkg::S_READ) |-> sh_q == '0 && bits_q == '0)
    else $error("missing dummy zero");
  a_addr_wrap: assert property ((fifo_push && word_mode_q && pf_addr_q == 7'h3f && f_q.cs && !rd_start)
    |=> pf_addr_q == '0)
    else $error("read address did not wrap");
  a_start_bit: assert property (start_ok && f_q.cs |=> st_q == eeprom_pkg::S_HDR)
    else $error("start bit not taken");
  a_hdr_stable: assert property ((st_q == eeprom_pkg::S_HDR && !sk_rise) |=> $stable(hdr_q))
    else $error("header changed without clock edge");
  a_no_prog_disabled: assert property ((cs_fall && st_q == eeprom_pkg::S_WAIT && !wen_q && !busy_q)
    |=> !busy_q)
    else $error("program cycle while disabled");
  a_prog_len: assert property ($rose(busy_q) |-> tmr_q == (prog_all ? TW'(PROG_ALL_CYC - 1) :
    TW'(PROG_ONE_CYC - 1)))
    else $error("program cycle length wrong");
  a_erase_ones: assert property ((prog_start && cmd_q.op == eeprom_pkg::OP_ERASE && word_mode_q)
    |=> mem_q[$past(cmd_q.addr[5:0])] == eeprom_pkg::ERASED)
    else $error("erased word not all ones");
  a_wen_reset: assert property ($fell(i_sys_rst) |-> !wen_q)
    else $error("writes enabled after reset");
  c_seq_wrap: cover property (fifo_push && pf_addr_q == 7'h3f && word_mode_q);
  c_write: cover property (prog_start && cmd_q.op == eeprom_pkg::OP_WRITE);
  c_status_release: cover property (show_q && start_ok);
  c_busy_poll: cover property (show_q && busy_q ##1 show_q && !busy_q);
endmodule : serial_eeprom_command_port

// >>> tb/host_model.sv
/*
  Host side of the serial command port: drives select, serial clock and data-in.
  Assumes the system clock is 4 ns; every change lands 1 ns after its rising edge.
*/
`timescale 1ns/1ns
module host_model (
  input wire logic i_clk_sys,
  input wire logic i_serial_out,
  input wire logic i_serial_out_oe,
  output logic o_cs,
  output logic o_sk,
  output logic o_din
);
  logic line;
  // ----------------------------------------------------------------
  // Data-out line as the host sees it
  // ----------------------------------------------------------------
  // Released line shows the inverse of the last level
  assign line = i_serial_out_oe ? i_serial_out : ~i_serial_out;
  initial
  begin
    o_cs = 1'b0;
    o_sk = 1'b0;
    o_din = 1'b0;
  end
  // ----------------------------------------------------------------
  // Pin sequencing
  // ----------------------------------------------------------------
  task automatic half();
    repeat (10) @(posedge i_clk_sys);
    #1;
  endtask : half
  task automatic set_cs(input logic v);
    o_cs = v;
    half();
  endtask : set_cs
  task automatic pulse(input logic b);
    o_din = b;
    half();
    o_sk = 1'b1;
    half();
    o_sk = 1'b0;
  endtask : pulse
  // Sends n bits MSB first, then clocks nrd more and collects nrd+1 output samples
  task automatic xfer(input logic [31:0] bits, input int n, input int nrd, output logic [63:0] rd);
    rd = 64'h0;
    set_cs(1'b1);
    for (int i = 0; i < n + nrd; i++)
    begin
      pulse(i < n ? bits[n-1-i] : 1'b0);
      if (i >= n - 1)
        rd = {rd[62:0], line};
    end
    set_cs(1'b0);
  endtask : xfer
endmodule : host_model

// >>> tb/serial_eeprom_command_port_test.sv
/*
  Self-checking bench for the serial command port.
  Assumes the host model drives the pins and short program cycle counts.
*/
`timescale 1ns/1ns
module serial_eeprom_command_port_test;
  localparam int unsigned ONE = 80;
  localparam int unsigned ALL = 120;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic organization_select = 1'b1;
  logic cs, sk, din, dout, dout_oe, busy, wen;
  logic [63:0] rd;
  int n_errors = 0;
  int total_checks = 0;
  int busy_n = 0;
  int busy_len = 0;
  always #2 clk_sys = ~clk_sys;
  serial_eeprom_command_port #(.PROG_ONE_CYC(ONE), .PROG_ALL_CYC(ALL), .FIFO_DEPTH(eeprom_pkg::FIFO_DEPTH))
    serial_eeprom_command_port_inst (.i_clk_sys(clk_sys), .i_sys_rst(sys_rst), .i_cs(cs),
    .i_serial_clock_in(sk), .i_serial_in(din), .i_organization_select(organization_select), .o_serial_out(dout),
    .o_serial_out_oe(dout_oe), .o_busy(busy), .o_write_enabled(wen));
  host_model host_model_inst (.i_clk_sys(clk_sys), .i_serial_out(dout), .i_serial_out_oe(dout_oe),
    .o_cs(cs), .o_sk(sk), .o_din(din));
  // Length of the last program cycle in system cycles
  always @(posedge clk_sys)
  begin
    if (busy === 1'b1)
      busy_n++;
    else if (busy_n != 0)
    begin
      busy_len = busy_n;
      busy_n = 0;
    end
  end
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : summarize
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    total_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wait_ready();
    for (int i = 0; i < 2000; i++)
    begin
      @(posedge clk_sys);
      #1;
      if (busy === 1'b0)
        return;
    end
    n_errors++;
    $display("CHECK FAILED busy wait expected 0 seen %b", busy);
    summarize();
  endtask : wait_ready
  task automatic cmd(input logic [31:0] bits, input int n);
    host_model_inst.xfer(bits, n, 0, rd);
  endtask : cmd
  task automatic wr_word(input logic [5:0] a, input logic [15:0] d);
    cmd({1'b1, eeprom_pkg::OP_WRITE, a, d}, 25);
  endtask : wr_word
  task automatic rd_words(input logic [5:0] a, input int nrd);
    host_model_inst.xfer({1'b1, eeprom_pkg::OP_READ, a}, 9, nrd, rd);
  endtask : rd_words
  task automatic ext(input logic [1:0] e);
    cmd({1'b1, eeprom_pkg::OP_EXT, e, 4'h0}, 9);
  endtask : ext
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_power_up();
    chk("oe idle", 64'h0, dout_oe);
    chk("latch", 64'h0, wen);
    rd_words(6'd5, 16);
    chk("read blank", 64'h0ffff, rd);
    chk("oe after read", 64'h0, dout_oe);
    $display("test power_up done");
  endtask : t_power_up
  task automatic t_locked_write();
    wr_word(6'd3, 16'h1234);
    repeat (10) @(posedge clk_sys);
    #1;
    chk("busy locked", 64'h0, busy);
    rd_words(6'd3, 16);
    chk("locked data", 64'h0ffff, rd);
    $display("test locked_write done");
  endtask : t_locked_write
  task automatic t_write_status();
    ext(eeprom_pkg::EXT_WEN);
    chk("latch set", 64'h1, wen);
    wr_word(6'd63, 16'ha5c3);
    chk("busy start", 64'h1, busy);
    host_model_inst.set_cs(1'b1);
    chk("status oe", 64'h1, dout_oe);
    chk("status busy", 64'h0, dout);
    host_model_inst.pulse(1'b1);
    chk("oe kept", 64'h1, dout_oe);
    wait_ready();
    repeat (4) @(posedge clk_sys);
    #1;
    chk("status ready", 64'h1, dout);
    host_model_inst.pulse(1'b1);
    repeat (2) @(posedge clk_sys);
    #1;
    chk("oe dismissed", 64'h0, dout_oe);
    host_model_inst.set_cs(1'b0);
    chk("one length", 64'h1, busy_len >= ONE - 1 && busy_len <= ONE + 1);
    $display("test write_status done");
  endtask : t_write_status
  task automatic t_seq_read();
    wr_word(6'd0, 16'h0f0f);
    wait_ready();
    rd_words(6'd63, 32);
    chk("stream wrap", {31'h0, 1'b0, 16'ha5c3, 16'h0f0f}, rd);
    $display("test seq_read done");
  endtask : t_seq_read
  task automatic t_erase_all();
    cmd({1'b1, eeprom_pkg::OP_ERASE, 6'd63}, 9);
    wait_ready();
    rd_words(6'd63, 16);
    chk("erased word", 64'h0ffff, rd);
    cmd({1'b1, eeprom_pkg::OP_EXT, eeprom_pkg::EXT_WRITE_ALL_CMD, 4'h0, 16'h1111}, 25);
    wait_ready();
    // The length monitor latches one edge after busy drops
    repeat (2) @(posedge clk_sys);
    #1;
    chk("all length", 64'h1, busy_len >= ALL - 1 && busy_len <= ALL + 1);
    rd_words(6'd62, 32);
    chk("write all", {31'h0, 1'b0, 32'h11111111}, rd);
    ext(eeprom_pkg::EXT_ERASE_ALL_CMD);
    wait_ready();
    rd_words(6'd0, 16);
    chk("erase all", 64'h0ffff, rd);
    $display("test erase_all done");
  endtask : t_erase_all
  task automatic t_disable();
    ext(eeprom_pkg::EXT_WDS);
    chk("latch clear", 64'h0, wen);
    wr_word(6'd5, 16'h0000);
    repeat (10) @(posedge clk_sys);
    #1;
    chk("busy off", 64'h0, busy);
    rd_words(6'd5, 16);
    chk("kept data", 64'h0ffff, rd);
    $display("test disable done");
  endtask : t_disable
  task automatic t_byte();
    organization_select = 1'b0;
    cmd({1'b1, eeprom_pkg::OP_EXT, eeprom_pkg::EXT_WEN, 5'h0}, 10);
    chk("byte latch", 64'h1, wen);
    cmd({1'b1, eeprom_pkg::OP_WRITE, 7'd1, 8'h5a}, 18);
    wait_ready();
    host_model_inst.xfer({1'b1, eeprom_pkg::OP_READ, 7'd127}, 10, 24, rd);
    chk("byte stream", {39'h0, 1'b0, 24'hffff5a}, rd);
    organization_select = 1'b1;
    rd_words(6'd0, 16);
    chk("word view", 64'h05aff, rd);
    $display("test byte done");
  endtask : t_byte
  initial
  begin
    repeat (2) @(posedge clk_sys);
    #1;
    sys_rst = 1'b0;
    repeat (10) @(posedge clk_sys);
    #1;
    t_power_up();
    t_locked_write();
    t_write_status();
    t_seq_read();
    t_erase_all();
    t_disable();
    t_byte();
    summarize();
  end
endmodule : serial_eeprom_command_port_test
